/* rtl/ioh_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef IOH_REGS_SVH
`define IOH_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define IOH_OFF_PIN_CFG      8'h54
`define IOH_OFF_STATUS       8'h58
`define IOH_OFF_MASK         8'h5C

// ----------------------------------------------------------------------
// interrupt_pin_config field positions
// ----------------------------------------------------------------------
`define IOH_CFG_INTERVAL_HI  31
`define IOH_CFG_INTERVAL_LO  24
`define IOH_CFG_RESTART      14
`define IOH_CFG_ACTIVE       13
`define IOH_CFG_MASTER       12
`define IOH_CFG_ENABLE       8
`define IOH_CFG_POLARITY     4
`define IOH_CFG_PUSH_PULL    0

// status bit of the power event source
`define IOH_POWER_EVENT_BIT  17

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IOH_RST_INTERVAL     8'h00
`define IOH_RST_STATUS       32'h00000000
`define IOH_RST_MASK         32'h00000000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define IOH_CLK_PERIOD_NS    5
`define IOH_TICK_NS          10000
`define IOH_TICK_CYCLES      ((`IOH_TICK_NS) / (`IOH_CLK_PERIOD_NS))

`endif

/* rtl/ioh_pkg.sv */
// types shared by the interrupt hold-off block
package ioh_pkg;

  // ----------------------------------------------------------------------
  // pin configuration held in interrupt_pin_config
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] holdoff_interval;
    logic       enable;
    logic       pin_polarity;
    logic       push_pull;
  } ioh_cfg_s;

  // interrupt pin as driven: level and active-low output enable
  typedef struct packed {
    logic level;
    logic oe_n;
  } ioh_pin_s;

  // hold-off timer state
  typedef enum logic {
    HO_IDLE = 1'b0,
    HO_RUN  = 1'b1
  } ioh_ho_state_e;

endpackage

/* rtl/ioh_holdoff_timer.sv */
// hold-off interval timer with 10 us prescaler
`timescale 1ns/10ps
`include "ioh_regs.svh"

module ioh_holdoff_timer
  import ioh_pkg::*;
#(
  parameter int TICK_CYCLES = `IOH_TICK_CYCLES
)(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] interval,
  input  wire logic       load,
  input  wire logic       clear,
  output logic            holdoff_active
);

  localparam int PW = $clog2(TICK_CYCLES);

  ioh_ho_state_e state_r, state_nxt;
  logic [PW-1:0] pre_r,   pre_nxt;
  logic [7:0]    cnt_r,   cnt_nxt;
  logic          tick;

  // prescaler wraps once per 10 us step
  assign tick = (pre_r == PW'(TICK_CYCLES - 1));

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    pre_nxt   = tick ? '0 : pre_r + 1'b1;
    cnt_nxt   = cnt_r;
    if (clear)
    begin
      state_nxt = HO_IDLE; // see R02
      cnt_nxt   = '0;
      pre_nxt   = '0;
    end
    else if (load)
    begin
      // restart aligns the prescaler so the step count is exact
      state_nxt = HO_RUN; // see R05
      cnt_nxt   = interval; // see R03
      pre_nxt   = '0;
    end
    else
    begin
      unique case (state_r)
        HO_IDLE: pre_nxt = '0;
        HO_RUN:
          if (tick)
          begin
            cnt_nxt = cnt_r - 1'b1; // see R01
            if (cnt_r == 8'h01)
              state_nxt = HO_IDLE;
          end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= HO_IDLE;
      pre_r   <= '0;
      cnt_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      pre_r   <= pre_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign holdoff_active = (state_r == HO_RUN); // see R06

  // prescaler period check
  chk_tick_spacing: assert property (@(posedge clk) disable iff (reset) // see R13
    (tick && !load && !clear) |=> ((pre_r == '0) && !tick))
    else $error("prescaler tick repeated too soon");

endmodule // ioh_holdoff_timer

/* rtl/ioh_irq_holdoff.sv */
// interrupt pin configuration, status, mask and hold-off control
//
// Operation
// R01 - hold-off interval in 10 us steps, bits 31:24
// R02 - zero interval disables, clears, releases pending
// R03 - new non-zero interval governs later interrupts
// R04 - power event never delayed by hold-off
// R05 - writing bit 14 restarts the hold-off interval
// R06 - bit 13 shows hold-off in progress
// R07 - bit 12 shows internal master interrupt line
// R08 - enable bit 8 clear keeps pin deasserted
// R09 - polarity bit 4 selects active level
// R10 - bit 0 selects open-drain or push-pull
// R11 - open-drain always active low, polarity ignored
// R12 - status bits cleared by writing one
// R13 - prescaled tick; interval starts on pin release
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "ioh_regs.svh"

module ioh_irq_holdoff
  import ioh_pkg::*;
#(
  parameter int N_EVENTS    = 32,
  parameter int TICK_CYCLES = `IOH_TICK_CYCLES
)(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [N_EVENTS-1:0] event_in,
  output logic                     irq_pin_o,
  output logic                     irq_pin_oe_n,
  output logic                     irq_master
);

  // ----------------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------------

  // register hit on a word-aligned byte address
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction

  // expand byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic                wait_r,     wait_nxt;
  logic [31:0]         rdata_r,    rdata_nxt;
  ioh_cfg_s            cfg_r,      cfg_nxt;
  logic [N_EVENTS-1:0] sts_r,      sts_nxt;
  logic [N_EVENTS-1:0] msk_r,      msk_nxt;
  logic                asserted_r, asserted_nxt;
  ioh_pin_s            pin_r,      pin_nxt;
  logic                master_r,   master_nxt;

  logic                wr_go;
  logic [31:0]         wmask;
  logic [31:0]         wbits;
  logic                restart;
  logic                ho_load;
  logic                ho_clear;
  logic                holdoff_active;
  logic [N_EVENTS-1:0] pend;
  logic                power_pend;
  logic                other_pend;
  logic [N_EVENTS-1:0] clr;

  // ----------------------------------------------------------------------
  // avalon handshake: one wait cycle, then one cycle with waitrequest low
  // ----------------------------------------------------------------------

  // a write commits only at the edge where waitrequest is seen low
  assign wr_go = avs_write && !wait_r;
  assign wmask = lane_mask(avs_byteenable);
  assign wbits = avs_writedata & wmask;

  // read data captured while waiting so it stands with waitrequest low
  always_comb
  begin
    wait_nxt  = !((avs_read || avs_write) && wait_r);
    rdata_nxt = rdata_r;
    if (avs_read && wait_r)
    begin
      rdata_nxt = 32'h00000000;
      if (hit(avs_address, `IOH_OFF_PIN_CFG))
      begin
        rdata_nxt[`IOH_CFG_INTERVAL_HI:`IOH_CFG_INTERVAL_LO] =
          cfg_r.holdoff_interval;
        rdata_nxt[`IOH_CFG_ACTIVE]    = holdoff_active; // see R06
        rdata_nxt[`IOH_CFG_MASTER]    = master_r; // see R07
        rdata_nxt[`IOH_CFG_ENABLE]    = cfg_r.enable;
        rdata_nxt[`IOH_CFG_POLARITY]  = cfg_r.pin_polarity;
        rdata_nxt[`IOH_CFG_PUSH_PULL] = cfg_r.push_pull;
      end
      else if (hit(avs_address, `IOH_OFF_STATUS))
        rdata_nxt[N_EVENTS-1:0] = sts_r;
      else if (hit(avs_address, `IOH_OFF_MASK))
        rdata_nxt[N_EVENTS-1:0] = msk_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // pin configuration register
  // ----------------------------------------------------------------------

  // restart bit is a strobe; it is never stored
  assign restart = wr_go && hit(avs_address, `IOH_OFF_PIN_CFG) &&
                   wbits[`IOH_CFG_RESTART]; // see R05

  always_comb
  begin
    cfg_nxt = cfg_r;
    if (wr_go && hit(avs_address, `IOH_OFF_PIN_CFG))
    begin
      if (avs_byteenable[3])
        cfg_nxt.holdoff_interval =
          avs_writedata[`IOH_CFG_INTERVAL_HI:`IOH_CFG_INTERVAL_LO]; // see R01
      if (avs_byteenable[1])
        cfg_nxt.enable = avs_writedata[`IOH_CFG_ENABLE];
      if (avs_byteenable[0])
      begin
        cfg_nxt.pin_polarity = avs_writedata[`IOH_CFG_POLARITY];
        cfg_nxt.push_pull    = avs_writedata[`IOH_CFG_PUSH_PULL];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfg_r.holdoff_interval <= `IOH_RST_INTERVAL;
      cfg_r.enable           <= 1'b0;
      cfg_r.pin_polarity     <= 1'b0;
      cfg_r.push_pull        <= 1'b0;
    end
    else
      cfg_r <= cfg_nxt;
  end

  // ----------------------------------------------------------------------
  // status and mask
  // ----------------------------------------------------------------------

  assign clr = (wr_go && hit(avs_address, `IOH_OFF_STATUS)) ?
               wbits[N_EVENTS-1:0] : '0;

  // set wins over clear so an event in the clearing cycle survives
  always_comb
  begin
    sts_nxt = (sts_r & ~clr) | event_in; // see R12
    msk_nxt = msk_r;
    if (wr_go && hit(avs_address, `IOH_OFF_MASK))
      msk_nxt = (msk_r & ~wmask[N_EVENTS-1:0]) | wbits[N_EVENTS-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sts_r <= `IOH_RST_STATUS;
      msk_r <= `IOH_RST_MASK;
    end
    else
    begin
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // hold-off timer
  // ----------------------------------------------------------------------

  assign pend       = sts_r & msk_r;
  assign power_pend = pend[`IOH_POWER_EVENT_BIT];
  assign other_pend = |(pend & ~(N_EVENTS'(1) << `IOH_POWER_EVENT_BIT));

  // zero interval takes effect in the cycle it is written
  assign ho_clear = (cfg_nxt.holdoff_interval == 8'h00); // see R02
  // a fresh interval on restart or when the pin lets go
  assign ho_load  = restart ||
                    (asserted_r && !asserted_nxt && !holdoff_active); // see R13

  ioh_holdoff_timer #(
    .TICK_CYCLES    (TICK_CYCLES)
  ) u_timer (
    .clk            (clk),
    .reset          (reset),
    .interval       (cfg_nxt.holdoff_interval),
    .load           (ho_load),
    .clear          (ho_clear),
    .holdoff_active (holdoff_active)
  );

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------

  // power event bypasses hold-off; enable gates the pin drive but not the master line
  always_comb
  begin
    master_nxt   = |pend; // see R07
    asserted_nxt = cfg_r.enable && // see R08
                   (power_pend || // see R04
                    (other_pend && !holdoff_active)); // see R06
    if (cfg_r.push_pull)
    begin
      pin_nxt.oe_n  = 1'b0; // see R10
      pin_nxt.level = cfg_r.pin_polarity ? asserted_nxt
                                         : !asserted_nxt; // see R09
    end
    else
    begin
      // released when idle so other drivers may share the wire
      pin_nxt.oe_n  = !asserted_nxt; // see R11
      pin_nxt.level = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      master_r   <= 1'b0;
      asserted_r <= 1'b0;
      pin_r      <= '{level: 1'b0, oe_n: 1'b1};
    end
    else
    begin
      master_r   <= master_nxt;
      asserted_r <= asserted_nxt;
      pin_r      <= pin_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign irq_pin_o       = pin_r.level;
  assign irq_pin_oe_n    = pin_r.oe_n;
  assign irq_master      = master_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_zero_interval_idle: assert property ( // see R02
    (cfg_r.holdoff_interval == 8'h00) |-> !holdoff_active)
    else $error("hold-off active with zero interval");

  chk_restart_starts: assert property ( // see R05
    (restart && cfg_nxt.holdoff_interval != 8'h00) |=> holdoff_active)
    else $error("restart did not start hold-off");

  chk_holdoff_blocks: assert property ( // see R01
    (holdoff_active && !power_pend) |=> !asserted_r)
    else $error("pin asserted during hold-off");

  chk_power_exempt: assert property ( // see R04
    (cfg_r.enable && power_pend) |=> asserted_r)
    else $error("power event delayed");

  // the pin register lags its config by one edge, so look back one edge
  chk_enable_gate: assert property ( // see R08
    !cfg_r.enable |=> ($past(cfg_r.push_pull) ?
      (!irq_pin_oe_n && irq_pin_o == !$past(cfg_r.pin_polarity)) :
      irq_pin_oe_n))
    else $error("pin asserted while disabled");

  chk_master_line: assert property ( // see R07
    (|pend) |=> irq_master ##0 ($past(|pend) == irq_master))
    else $error("master line wrong");

  chk_open_drain: assert property ( // see R11
    !$past(cfg_r.push_pull) |-> (!irq_pin_o &&
                                 irq_pin_oe_n == !asserted_r))
    else $error("open-drain pin not active low");

  chk_push_pull: assert property ( // see R09
    $past(cfg_r.push_pull) |-> (!irq_pin_oe_n &&
      irq_pin_o == (asserted_r ~^ $past(cfg_r.pin_polarity))))
    else $error("push-pull level wrong");

  chk_w1c_clear: assert property ( // see R12
    (|clr) |=> ((sts_r & $past(clr) & ~$past(event_in)) == '0))
    else $error("status bit not cleared");

  chk_release_starts: assert property ( // see R13
    (asserted_r && !asserted_nxt && !holdoff_active && !ho_clear)
      |=> holdoff_active)
    else $error("hold-off not started on release");

  // a zero interval must let pending interrupts straight through
  chk_zero_delivers: assert property ( // see R02
    (cfg_r.holdoff_interval == 8'h00 && cfg_r.enable && other_pend)
      |=> asserted_r)
    else $error("pending interrupt held with zero interval");

  chk_cfg_readback: assert property ( // see R06
    (avs_read && wait_r && hit(avs_address, `IOH_OFF_PIN_CFG)) |=>
      (avs_readdata[`IOH_CFG_ACTIVE] == $past(holdoff_active) &&
       !avs_readdata[`IOH_CFG_RESTART]))
    else $error("config readback of hold-off state wrong");

  cov_holdoff_run: cover property (
    asserted_r ##1 !asserted_r ##1 holdoff_active [*3]);

  cov_power_in_holdoff: cover property (
    holdoff_active && power_pend && asserted_r);

  cov_restart_running: cover property (holdoff_active && restart);

  cov_zero_release: cover property (
    holdoff_active && other_pend ##1 ho_clear ##2 asserted_r);

  cov_restart_idle: cover property (
    restart && !holdoff_active && cfg_nxt.holdoff_interval != 8'h00);

endmodule // ioh_irq_holdoff

/* tb/ioh_host_model.sv */
// host side model: interrupt input of the host cpu with pull-up
`timescale 1ns/10ps

module ioh_host_model (
  input  wire logic pin_level,
  input  wire logic pin_oe_n,
  input  wire logic active_high,
  output logic      wire_level,
  output logic      irq_seen
);
  // ------------------------------------------------------------
  // shared interrupt wire
  // ------------------------------------------------------------
  // a released wire floats to the pull-up, never to the last value
  assign wire_level = pin_oe_n ? 1'b1 : pin_level;
  // host decodes with the level it believes is the asserted one
  assign irq_seen   = active_high ? wire_level : !wire_level;
endmodule // ioh_host_model

/* tb/ioh_irq_holdoff_tb.sv */
// self-checking bench for the interrupt pin hold-off block
`timescale 1ns/10ps
`include "ioh_regs.svh"

module ioh_irq_holdoff_tb;
  // short tick keeps hold-off intervals to a few cycles
  localparam int TICK = 4;
  logic        clk;
  logic        reset;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] event_in;
  logic        irq_pin_o;
  logic        irq_pin_oe_n;
  logic        irq_master;
  logic        host_hi;
  logic        wire_level;
  logic        irq_seen;
  logic [31:0] rdata;
  logic [31:0] cfgs [3];
  int          num_errors;
  int          checks_done;
  int          n;

  ioh_irq_holdoff #(.N_EVENTS(32), .TICK_CYCLES(TICK)) i_ioh_irq_holdoff (
    .clk             (clk),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .event_in        (event_in),
    .irq_pin_o       (irq_pin_o),
    .irq_pin_oe_n    (irq_pin_oe_n),
    .irq_master      (irq_master)
  );

  ioh_host_model i_ioh_host_model (
    .pin_level   (irq_pin_o),
    .pin_oe_n    (irq_pin_oe_n),
    .active_high (host_hi),
    .wire_level  (wire_level),
    .irq_seen    (irq_seen)
  );

  // ------------------------------------------------------------
  // clock and watchdog
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole run is under two hundred cycles; some twenty-five times that means a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end

  // ------------------------------------------------------------
  // report and compare
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------
  // bus and stimulus tasks
  // ------------------------------------------------------------
  // request held until waitrequest is sampled low, then dropped
  // a slave that never answers is ended by the watchdog
  task automatic bus_access(input logic wr_n_rd, input logic [7:0] a,
                            input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_read       <= !wr_n_rd;
    avs_write      <= wr_n_rd;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_access(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus_access(1'b0, a, 32'h00000000, 4'hF);
    check_word(rdata, exp);
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    event_in <= 32'h00000001 << b;
    @(posedge clk);
    event_in <= 32'h00000000;
  endtask

  // outputs are looked at mid-cycle, where they have settled
  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask

  // restart with interval iv and time the pin's return
  task automatic holdoff_run(input int iv);
    wr(`IOH_OFF_PIN_CFG, (iv << 24) | 32'h00004100);
    settle(3);
    check_bit(irq_seen, 1'b0);
    n = 0;
    while (irq_seen !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check_bit(n >= (iv - 1) * TICK && n <= iv * TICK + 6, 1'b1);
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    reset          = 1'b1;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'hF;
    event_in       = 32'h00000000;
    host_hi        = 1'b0;
    num_errors     = 0;
    checks_done    = 0;
    cfgs = '{32'h00000110, 32'h00000101, 32'h00000111};
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd_chk(`IOH_OFF_PIN_CFG, 32'h00000000);
    rd_chk(`IOH_OFF_STATUS, 32'h00000000);
    rd_chk(`IOH_OFF_MASK, 32'h00000000);
    wr(8'h60, 32'hFFFFFFFF);
    rd_chk(8'h60, 32'h00000000);
    check_bit(irq_pin_oe_n, 1'b1);
    end_test("reset");
    wr(`IOH_OFF_MASK, 32'h00020008);
    rd_chk(`IOH_OFF_MASK, 32'h00020008);
    pulse(3);
    pulse(5);
    settle(2);
    check_bit(irq_master, 1'b1);
    check_bit(irq_pin_oe_n, 1'b1);
    rd_chk(`IOH_OFF_STATUS, 32'h00000028);
    rd_chk(`IOH_OFF_PIN_CFG, 32'h00001000);
    wr(`IOH_OFF_STATUS, 32'h00000020);
    rd_chk(`IOH_OFF_STATUS, 32'h00000008);
    end_test("events");
    // only lane 1 written: enable set, interval left at zero
    bus_access(1'b1, `IOH_OFF_PIN_CFG, 32'hFF000100, 4'h2);
    rd_chk(`IOH_OFF_PIN_CFG, 32'h00001100);
    for (int i = 0; i < 3; i++)
    begin
      wr(`IOH_OFF_PIN_CFG, cfgs[i]);
      host_hi <= cfgs[i][0] & cfgs[i][4];
      settle(3);
      check_bit(irq_pin_o, cfgs[i][0] & cfgs[i][4]);
      check_bit(irq_pin_oe_n, 1'b0);
      rd_chk(`IOH_OFF_PIN_CFG, cfgs[i] | 32'h00001000);
    end
    wr(`IOH_OFF_STATUS, 32'h00000008);
    settle(3);
    check_bit(irq_pin_o, 1'b0);
    check_bit(irq_pin_oe_n, 1'b0);
    wr(`IOH_OFF_PIN_CFG, 32'h00000100);
    host_hi <= 1'b0;
    settle(3);
    check_bit(irq_pin_oe_n, 1'b1);
    pulse(3);
    settle(3);
    check_bit(irq_seen, 1'b1);
    end_test("pin");
    holdoff_run(1);
    holdoff_run(3);
    holdoff_run(6);
    end_test("holdoff");
    wr(`IOH_OFF_PIN_CFG, 32'h06004100);
    rd_chk(`IOH_OFF_PIN_CFG, 32'h06003100);
    pulse(17);
    settle(3);
    check_bit(irq_seen, 1'b1);
    wr(`IOH_OFF_STATUS, 32'h00020000);
    settle(3);
    check_bit(irq_seen, 1'b0);
    wr(`IOH_OFF_PIN_CFG, 32'h00000100);
    settle(3);
    check_bit(irq_seen, 1'b1);
    rd_chk(`IOH_OFF_PIN_CFG, 32'h00001100);
    end_test("release");
    final_report();
  end
endmodule // ioh_irq_holdoff_tb
